/* pkg/mapper_consts.svh */
// constants for the double-slot key stream mapper
`ifndef MAPPER_CONSTS_SVH
`define MAPPER_CONSTS_SVH

// segment bit index width and segment bounds
`define IDX_W 10
`define SEG_LAST 10'h347
`define TAIL_LAST 10'h027
`define B_FIRST 10'h028
`define SINGLE_LAST 10'h327
`define MULTI_LAST 10'h337
`define SUB_STRIDE 10'h050
`define SUB_DATA_LAST 10'h03f
`define SUB_COUNT 10

// concatenated key stream per frame
`define CONCAT_W 11
`define CONCAT_LEN 11'h690

// reset values
`define MODE_RST 1'b0

`endif

/* pkg/mapper_pkg.sv */
// types shared by the key stream mapper files
package mapper_pkg;

   // b-field layouts
   typedef enum logic [1:0] {
      FMT_UNPROT,
      FMT_SINGLE,
      FMT_MULTI
   } fmt_e;

   // modulation configurations
   typedef enum logic [2:0] {
      CFG_1A,
      CFG_1B,
      CFG_2,
      CFG_3,
      CFG_4A,
      CFG_4B,
      CFG_5,
      CFG_6
   } mod_cfg_e;

   // segment walker states
   typedef enum logic {
      ST_IDLE,
      ST_RUN
   } seg_state_e;

endpackage : mapper_pkg

/* hw/key_bit_gate.sv */
// decides whether one key stream segment bit is applied to its field bit
`timescale 1ns/1ps
`default_nettype none
`include "mapper_consts.svh"

module key_bit_gate
   import mapper_pkg::*;
(
   // position and layout
   input wire logic [`IDX_W-1:0] idx,
   input wire fmt_e burst_format,
   input wire logic tail_is_ctl,
   // verdict
   output logic apply
);

   logic [`SUB_COUNT-1:0] in_sub;

   // one window per subfield: 64 data bits, then 16 check bits left clear
   genvar k;
   generate
      for (k = 0; k < `SUB_COUNT; k++) begin : g_sub
         localparam logic [`IDX_W-1:0] LO = `B_FIRST + `SUB_STRIDE * 10'(k);
         assign in_sub[k] = (idx >= LO) && (idx <= LO + `SUB_DATA_LAST); // see R6 see R7 see R8
      end
   endgenerate

   // tail part first, then the b-field layout
   always_comb begin
      if (idx <= `TAIL_LAST) begin
         apply = tail_is_ctl; // see R2 see R3
      end else begin
         case (burst_format)
            FMT_UNPROT: apply = 1'b1; // see R4
            FMT_SINGLE: apply = (idx <= `SINGLE_LAST); // see R5 see R18
            FMT_MULTI: apply = |in_sub; // see R18
            default: apply = 1'b0;
         endcase
      end
   end

endmodule : key_bit_gate
`default_nettype wire

/* hw/double_slot_keystream_xor_mapper.sv */
// bit-serial xor of key stream segments onto double-slot mac fields
// Notes on behaviour
// R1: two 840-bit segments, indices 0 to 839
// R2: control tail: segment 0..39 onto tail 8..47
// R3: other tail: bits 0..39 dropped, tail clear
// R4: unprotected: segment 40..839 onto b 0..799
// R5: single subfield: 40..807 used, check clear
// R6: multisubfield: 40..103 onto b0, 104..119 skipped
// R7: subfield k uses 40+80k..103+80k
// R8: last subfield 760..823, 824..839 unused
// R9: 1680 concatenated key bits per frame
// R10: each bearer ciphered, own frame-derived init value
// R11: simplex transmit: first fixed, second portable segment
// R12: simplex receive: first fixed, second portable segment
// R13: mode switched on duplex bearer, all bearers; handover leg follows handover_cipher_on instead
// R14: one mode reported for whole connection
// R15: connections of one call share mode
// R16: control-plane data clear unless routed ciphered; handover leg ignores it, gated by handover_cipher_on only
// R17: eight modulation configurations accepted
// R18: higher modulation: checks and x-field clear
// R19: handover legs share identical segment pairs
// R20: index restarts per segment, format latched first
`timescale 1ns/1ps
`default_nettype none
`include "mapper_consts.svh"

module double_slot_keystream_xor_mapper
   import mapper_pkg::*;
#(
   parameter int FN_W = 4,
   parameter int MFN_W = 24
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // frame timing
   input wire logic frame_start,
   input wire logic [FN_W-1:0] frame_number,
   input wire logic [MFN_W-1:0] multiframe_number,
   // segment setup, sampled on seg_start
   input wire logic seg_start,
   input wire fmt_e burst_format,
   input wire mod_cfg_e mod_config,
   input wire logic tail_is_ctl,
   input wire logic cplane_field,
   input wire logic routed_to_ciphered_lc,
   input wire logic double_simplex,
   input wire logic second_field,
   input wire logic tx_dir,
   input wire logic fixed_side,
   // bit stream
   input wire logic bit_valid,
   input wire logic fixed_side_segment_bit,
   input wire logic portable_side_segment_bit,
   input wire logic field_bit,
   input wire logic handover_field_bit,
   input wire logic handover_cipher_on,
   // mode control
   input wire logic mode_req,
   input wire logic mode_req_on,
   input wire logic mode_req_duplex,
   input wire logic mode_req_local,
   // mapped stream
   output logic out_valid_q,
   output logic out_bit_q,
   output logic handover_out_bit_q,
   output logic busy_q,
   output logic seg_done_q,
   // frame status
   output logic pair_done_q,
   output logic [`CONCAT_W-1:0] key_bits_used_q,
   output logic init_load_q,
   output logic [FN_W+MFN_W-1:0] init_value_q,
   // connection mode
   output logic cipher_mode_q,
   output logic cipher_mode_indication_q,
   output logic cipher_mode_confirmation_q,
   output mod_cfg_e mod_config_q
);

   seg_state_e state_q;
   logic [`IDX_W-1:0] idx_q;
   fmt_e fmt_q;
   logic tail_ctl_q;
   logic use_fixed_q;
   logic seg_cipher_q;
   logic apply;
   logic key_bit;
   logic mask;
   logic take;
   logic last_bit;

   // which of the two segments this d-field uses
   function automatic logic pick_fixed(input logic simplex, input logic second, input logic tx,
                                       input logic fixed);
      if (simplex) begin
         pick_fixed = !second; // see R11 see R12
      end else begin
         pick_fixed = (tx == fixed);
      end
   endfunction : pick_fixed

   // position decoder
   key_bit_gate u_gate (
      .idx(idx_q),
      .burst_format(fmt_q),
      .tail_is_ctl(tail_ctl_q),
      .apply(apply)
   );

   // a bit offered in a restart cycle is dropped, so the restart never counts it
   assign take = (state_q == ST_RUN) && bit_valid && !seg_start;
   assign last_bit = (idx_q == `SEG_LAST);
   assign key_bit = use_fixed_q ? fixed_side_segment_bit : portable_side_segment_bit;
   assign mask = apply && seg_cipher_q;

   // segment walker: format and mode frozen for the whole segment
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         busy_q <= 1'b0;
         idx_q <= '0;
         fmt_q <= FMT_UNPROT;
         tail_ctl_q <= 1'b0;
         use_fixed_q <= 1'b1;
         seg_cipher_q <= 1'b0;
         mod_config_q <= CFG_1A;
      end else if (seg_start) begin
         state_q <= ST_RUN;
         busy_q <= 1'b1;
         idx_q <= '0; // see R20
         fmt_q <= burst_format; // see R20
         tail_ctl_q <= tail_is_ctl;
         use_fixed_q <= pick_fixed(double_simplex, second_field, tx_dir, fixed_side);
         // control-plane traffic stays clear unless steered to a ciphered link
         seg_cipher_q <= cipher_mode_q && (!cplane_field || routed_to_ciphered_lc); // see R16
         mod_config_q <= mod_config; // see R17
      end else if (take) begin
         case (state_q)
            ST_RUN: begin
               if (last_bit) begin
                  state_q <= ST_IDLE; // see R1
                  busy_q <= 1'b0;
                  idx_q <= '0;
               end else begin
                  idx_q <= idx_q + 10'h001;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               busy_q <= 1'b0;
            end
         endcase
      end
   end

   // xor stage; the handover leg reuses the very same key bit
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         out_valid_q <= 1'b0;
         out_bit_q <= 1'b0;
         handover_out_bit_q <= 1'b0;
         seg_done_q <= 1'b0;
      end else begin
         out_valid_q <= take;
         seg_done_q <= take && last_bit;
         if (take) begin
            out_bit_q <= field_bit ^ (key_bit & mask);
            handover_out_bit_q <= handover_field_bit ^ (key_bit & apply & handover_cipher_on); // see R19
         end
      end
   end

   // per-frame key accounting and this bearer's init value
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         key_bits_used_q <= '0;
         pair_done_q <= 1'b0;
         init_load_q <= 1'b0;
         init_value_q <= '0;
      end else begin
         init_load_q <= frame_start;
         pair_done_q <= 1'b0;
         if (frame_start) begin
            key_bits_used_q <= '0;
            init_value_q <= {multiframe_number, frame_number}; // see R10
         end else if (take && key_bits_used_q != `CONCAT_LEN) begin
            key_bits_used_q <= key_bits_used_q + 11'h001; // see R9
            pair_done_q <= (key_bits_used_q == `CONCAT_LEN - 11'h001);
         end
      end
   end

   // one mode for the connection, taken only from a duplex bearer
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cipher_mode_q <= `MODE_RST;
         cipher_mode_indication_q <= 1'b0;
         cipher_mode_confirmation_q <= 1'b0;
      end else begin
         cipher_mode_indication_q <= mode_req && mode_req_duplex && !mode_req_local; // see R14
         cipher_mode_confirmation_q <= mode_req && mode_req_duplex && mode_req_local; // see R14
         if (mode_req && mode_req_duplex) begin
            cipher_mode_q <= mode_req_on; // see R13 see R15
         end
      end
   end

   // checks on the mapping
   sequence s_pos(logic [`IDX_W-1:0] lo, logic [`IDX_W-1:0] hi);
      take && idx_q >= lo && idx_q <= hi;
   endsequence

   property p_clear_tail;
      @(posedge clock) disable iff (!rstn)
         s_pos(10'h000, `TAIL_LAST) ##0 !tail_ctl_q |=> out_bit_q == $past(field_bit);
   endproperty
   a_clear_tail: assert property (p_clear_tail) else $error("tail ciphered without control type"); // see R3

   property p_ctl_tail;
      @(posedge clock) disable iff (!rstn)
         s_pos(10'h000, `TAIL_LAST) ##0 (tail_ctl_q && seg_cipher_q)
         |=> out_bit_q == ($past(field_bit) ^ $past(key_bit));
   endproperty
   a_ctl_tail: assert property (p_ctl_tail) else $error("control tail not ciphered"); // see R2

   property p_unprot;
      @(posedge clock) disable iff (!rstn)
         s_pos(`B_FIRST, `SEG_LAST) ##0 (fmt_q == FMT_UNPROT && seg_cipher_q)
         |=> out_bit_q == ($past(field_bit) ^ $past(key_bit));
   endproperty
   a_unprot: assert property (p_unprot) else $error("unprotected b bit not ciphered"); // see R4

   property p_single_check;
      @(posedge clock) disable iff (!rstn)
         s_pos(`SINGLE_LAST + 10'h001, `SEG_LAST) ##0 fmt_q == FMT_SINGLE
         |=> out_bit_q == $past(field_bit);
   endproperty
   a_single_check: assert property (p_single_check) else $error("single check word ciphered"); // see R5

   property p_multi_gap;
      @(posedge clock) disable iff (!rstn)
         s_pos(10'h068, 10'h077) ##0 fmt_q == FMT_MULTI |=> out_bit_q == $past(field_bit);
   endproperty
   a_multi_gap: assert property (p_multi_gap) else $error("first subfield check ciphered"); // see R6

   property p_multi_tail;
      @(posedge clock) disable iff (!rstn)
         s_pos(`MULTI_LAST + 10'h001, `SEG_LAST) ##0 fmt_q == FMT_MULTI
         |=> out_bit_q == $past(field_bit);
   endproperty
   a_multi_tail: assert property (p_multi_tail) else $error("last subfield check ciphered"); // see R8

   property p_sub1;
      @(posedge clock) disable iff (!rstn)
         s_pos(10'h078, 10'h0b7) ##0 (fmt_q == FMT_MULTI && seg_cipher_q)
         |=> out_bit_q == ($past(field_bit) ^ $past(key_bit));
   endproperty
   a_sub1: assert property (p_sub1) else $error("subfield one data not ciphered"); // see R7

   sequence s_last;
      take && last_bit && !seg_start;
   endsequence

   property p_seg_end;
      @(posedge clock) disable iff (!rstn)
         s_last |=> (seg_done_q && !busy_q && idx_q == 10'h000) ##1 !seg_done_q;
   endproperty
   a_seg_end: assert property (p_seg_end) else $error("segment did not end at bit 839"); // see R1

   property p_restart;
      @(posedge clock) disable iff (!rstn)
         seg_start |=> idx_q == 10'h000 && busy_q && fmt_q == $past(burst_format);
   endproperty
   a_restart: assert property (p_restart) else $error("segment start did not reset index"); // see R20

   property p_simplex_pick;
      @(posedge clock) disable iff (!rstn)
         seg_start && double_simplex |=> use_fixed_q == !$past(second_field);
   endproperty
   a_simplex_pick: assert property (p_simplex_pick) else $error("wrong segment for simplex field"); // see R11

   property p_mode;
      @(posedge clock) disable iff (!rstn)
         mode_req && mode_req_duplex |=> cipher_mode_q == $past(mode_req_on)
         && (cipher_mode_indication_q || cipher_mode_confirmation_q);
   endproperty
   a_mode: assert property (p_mode) else $error("duplex mode request not applied"); // see R13

   property p_mode_hold;
      @(posedge clock) disable iff (!rstn)
         !(mode_req && mode_req_duplex) |=> $stable(cipher_mode_q);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode changed without duplex request"); // see R14

   property p_cplane;
      @(posedge clock) disable iff (!rstn)
         seg_start && cplane_field && !routed_to_ciphered_lc |=> !seg_cipher_q;
   endproperty
   a_cplane: assert property (p_cplane) else $error("unrouted control plane ciphered"); // see R16

   property p_concat;
      @(posedge clock) disable iff (!rstn)
         pair_done_q |-> key_bits_used_q == `CONCAT_LEN;
   endproperty
   a_concat: assert property (p_concat) else $error("pair done away from 1680 bits"); // see R9

endmodule : double_slot_keystream_xor_mapper
`default_nettype wire

/* verification/keystream_source.sv */
// partner model: pseudo-random key stream generator feeding both segments
`timescale 1ns/1ps
`default_nettype none

module keystream_source (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // segment bits of one index
   output logic fixed_bit,
   output logic portable_bit
);
   logic [15:0] lfsr_q;

   // free-running lfsr, so a stale bit never looks valid: the state advances every cycle
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lfsr_q <= 16'hace1;
      end else begin
         lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      end
   end

   // one pair stream shared by both handover legs
   assign fixed_bit = lfsr_q[0];
   assign portable_bit = lfsr_q[7];
endmodule : keystream_source

`default_nettype wire

/* verification/test_double_slot_keystream_xor_mapper.sv */
// self-checking bench for the double-slot key stream mapper
`timescale 1ns/1ps
`default_nettype none
`include "mapper_consts.svh"

module test_double_slot_keystream_xor_mapper
   import mapper_pkg::*;
();
   logic clock, rstn, frame_start, seg_start, tail_is_ctl, cplane_field, routed_to_ciphered_lc;
   logic double_simplex, second_field, tx_dir, fixed_side, bit_valid, field_bit, handover_field_bit;
   logic handover_cipher_on, mode_req, mode_req_on, mode_req_duplex, mode_req_local;
   logic fixed_side_segment_bit, portable_side_segment_bit, mode_exp;
   logic [3:0] frame_number;
   logic [23:0] multiframe_number;
   fmt_e burst_format;
   mod_cfg_e mod_config, mod_config_q;
   logic out_valid_q, out_bit_q, handover_out_bit_q, busy_q, seg_done_q, pair_done_q, init_load_q;
   logic cipher_mode_q, cipher_mode_indication_q, cipher_mode_confirmation_q;
   logic [`CONCAT_W-1:0] key_bits_used_q;
   logic [27:0] init_value_q;
   int n_fail = 0;
   int checks = 0;
   int cycles = 0;
   int kb = 0;
   int nseg = 0;
   integer seed = 32'h5ea5;

   double_slot_keystream_xor_mapper u_double_slot_keystream_xor_mapper (.clock, .rstn, .frame_start,
      .frame_number, .multiframe_number, .seg_start, .burst_format, .mod_config, .tail_is_ctl, .cplane_field,
      .routed_to_ciphered_lc, .double_simplex, .second_field, .tx_dir, .fixed_side, .bit_valid,
      .fixed_side_segment_bit, .portable_side_segment_bit, .field_bit, .handover_field_bit,
      .handover_cipher_on, .mode_req, .mode_req_on, .mode_req_duplex, .mode_req_local, .out_valid_q,
      .out_bit_q, .handover_out_bit_q, .busy_q, .seg_done_q, .pair_done_q, .key_bits_used_q, .init_load_q,
      .init_value_q, .cipher_mode_q, .cipher_mode_indication_q, .cipher_mode_confirmation_q, .mod_config_q);

   keystream_source u_keystream_source (.clock, .rstn, .fixed_bit(fixed_side_segment_bit),
      .portable_bit(portable_side_segment_bit));

   // 20 mhz clock
   initial clock = 1'b0;
   always #25 clock = ~clock;

   // compare tasks and closing report
   task automatic chk_b(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL %s exp %b got %b", nm, e, g);
      end
   endtask : chk_b

   task automatic chk_w(input string nm, input logic [27:0] e, input logic [27:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL %s exp %h got %h", nm, e, g);
      end
   endtask : chk_w

   task automatic give_verdict();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict

   // whether segment bit i is applied for this layout
   function automatic logic used(input int i, input fmt_e f, input logic t);
      if (i < 40) return t;
      if (f == FMT_UNPROT) return 1'b1;
      if (f == FMT_SINGLE) return i <= 807;
      return ((i - 40) % 80) < 64;
   endfunction : used

   // cut a hang short
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         give_verdict();
      end
   end

   task automatic set_mode(input logic on, input logic loc, input logic dup);
      @(posedge clock);
      #1;
      {mode_req, mode_req_on, mode_req_local, mode_req_duplex} = {1'b1, on, loc, dup};
      @(posedge clock);
      #1;
      mode_req = 1'b0;
      if (dup) mode_exp = on;
      chk_b("cipher_mode_q", mode_exp, cipher_mode_q);
      chk_b("cipher_mode_indication_q", dup & !loc, cipher_mode_indication_q);
      chk_b("cipher_mode_confirmation_q", dup & loc, cipher_mode_confirmation_q);
   endtask : set_mode

   task automatic new_frame();
      frame_number = 4'($random(seed));
      multiframe_number = 24'($random(seed));
      frame_start = 1'b1;
      @(posedge clock);
      #1;
      frame_start = 1'b0;
      kb = 0;
      chk_b("init_load_q", 1'b1, init_load_q);
      chk_w("init_value_q", {multiframe_number, frame_number}, init_value_q);
      chk_w("key_bits_used_q", 28'h0, 28'(key_bits_used_q));
   endtask : new_frame

   // one segment of n bits, random setup; a short n leaves it for a restart
   task automatic run_seg(input fmt_e f, input int n);
      logic key, e, he;
      int old;
      burst_format = f;
      mod_config = mod_cfg_e'(3'(nseg));
      nseg++;
      {tail_is_ctl, cplane_field, routed_to_ciphered_lc, double_simplex, second_field, tx_dir, fixed_side,
         handover_cipher_on} = 8'($random(seed));
      seg_start = 1'b1;
      bit_valid = 1'b0;
      @(posedge clock);
      #1;
      seg_start = 1'b0;
      chk_w("mod_config_q", 28'(mod_config), 28'(mod_config_q));
      chk_b("busy_q", 1'b1, busy_q);
      for (int i = 0; i < n; i++) begin
         key = double_simplex ? (second_field ? portable_side_segment_bit : fixed_side_segment_bit) :
            (tx_dir == fixed_side ? fixed_side_segment_bit : portable_side_segment_bit);
         field_bit = 1'($random(seed));
         handover_field_bit = 1'($random(seed));
         bit_valid = 1'b1;
         e = field_bit ^ (key & used(i, f, tail_is_ctl) & mode_exp & !(cplane_field & !routed_to_ciphered_lc));
         he = handover_field_bit ^ (key & used(i, f, tail_is_ctl) & handover_cipher_on);
         @(posedge clock);
         #1;
         old = kb;
         kb = (kb < 1680) ? kb + 1 : kb;
         chk_b("out_valid_q", 1'b1, out_valid_q);
         chk_b("out_bit_q", e, out_bit_q);
         chk_b("handover_out_bit_q", he, handover_out_bit_q);
         chk_b("seg_done_q", i == 839, seg_done_q);
         chk_b("busy_q", i != 839, busy_q);
         chk_w("key_bits_used_q", 28'(kb), 28'(key_bits_used_q));
         chk_b("pair_done_q", kb == 1680 && old == 1679, pair_done_q);
      end
   endtask : run_seg

   // main sequence
   initial begin
      {frame_start, seg_start, tail_is_ctl, cplane_field, routed_to_ciphered_lc, double_simplex} = '0;
      {second_field, tx_dir, fixed_side, bit_valid, field_bit, handover_field_bit, handover_cipher_on} = '0;
      {mode_req, mode_req_on, mode_req_duplex, mode_req_local, mode_exp} = '0;
      frame_number = 4'h0;
      multiframe_number = 24'h0;
      burst_format = FMT_UNPROT;
      mod_config = CFG_1A;
      rstn = 1'b0;
      repeat (2) @(posedge clock);
      #1;
      rstn = 1'b1;
      chk_b("cipher_mode_q", 1'b0, cipher_mode_q);
      chk_w("mod_config_q", 28'(CFG_1A), 28'(mod_config_q));
      set_mode(1'b1, 1'b0, 1'b1);
      set_mode(1'b0, 1'b1, 1'b0);
      new_frame();
      // count past 1680 to see saturation
      for (int c = 0; c < 12; c++) begin
         run_seg(fmt_e'(2'(c % 3)), 840);
      end
      new_frame();
      run_seg(FMT_MULTI, 100);
      run_seg(FMT_SINGLE, 840);
      set_mode(1'b0, 1'b1, 1'b1);
      run_seg(FMT_UNPROT, 840);
      give_verdict();
   end
endmodule : test_double_slot_keystream_xor_mapper

`default_nettype wire
